// File: rtl/palette_pkg.sv
package palette_pkg;

	// ============================================================
	// register map (byte addresses on apb)
	localparam logic [7:0] OFF_WADDR  = 8'h00;
	localparam logic [7:0] OFF_RADDR  = 8'h04;
	localparam logic [7:0] OFF_HOLD   = 8'h08;
	localparam logic [7:0] OFF_PAGE   = 8'h0c;
	localparam logic [7:0] OFF_MASK   = 8'h10;
	localparam logic [7:0] OFF_CTRL   = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;

	// ============================================================
	// reset values
	localparam logic [7:0] PAGE_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'hff;
	localparam logic [7:0] ADDR_RST = 8'h00;

	// ============================================================
	// field positions in the control word
	localparam int CTRL_DEPTH8_BIT = 0;
	localparam int CTRL_PLANES_LSB = 1;
	localparam int CTRL_DIRECT_BIT = 3;
	localparam int CTRL_W          = 4;

	// six-bit colour: width of the significant field
	localparam int SIX_W = 6;

	typedef enum logic [1:0] {
		PLANES_8 = 2'b00,
		PLANES_4 = 2'b01,
		PLANES_2 = 2'b10,
		PLANES_1 = 2'b11
	} plane_mode_t;

	typedef enum logic [1:0] {
		PH_RED   = 2'b00,
		PH_GREEN = 2'b01,
		PH_BLUE  = 2'b10
	} phase_t;

	typedef struct packed {
		logic        direct;
		plane_mode_t planes;
		logic        depth8;
	} ctrl_t;

	localparam ctrl_t CTRL_RST = '{direct: 1'b0, planes: PLANES_8, depth8: 1'b1};

	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} color_t;

endpackage

// File: rtl/palette_ram.sv
`timescale 1ns/1ps
// two independent ports: host side reads asynchronously, pixel side is registered
module palette_ram (
	input  wire logic                   mclk_i,
	input  wire logic                   ce_i,
	input  wire logic                   we_i,
	input  wire logic [7:0]             waddr_i,
	input  wire palette_pkg::color_t    wdata_i,
	input  wire logic [7:0]             haddr_i,
	output palette_pkg::color_t         hdata_o,
	input  wire logic [7:0]             paddr_i,
	output palette_pkg::color_t         pdata_o
);

	palette_pkg::color_t mem [0:255];

	assign hdata_o = mem[haddr_i];

	always_ff @(posedge mclk_i) begin
		if (ce_i && we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	// pixel port never waits on the host port
	always_ff @(posedge mclk_i) begin
		if (ce_i) begin
			pdata_o <= mem[paddr_i];
		end
	end

endmodule

// File: rtl/palette_access.sv
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - red, green, blue writes store one entry
// - address advances after each stored entry
// - read-mode address fetches entry, then increments
// - three reads return red, green, blue
// - after blue read, fetch next, increment again
// - pixel lookups use separate RAM port
// - four planes: pixels low, page high
// - two, one, eight plane address split
// - page bits keep their own positions
// - pixel bits ANDed with mask, pseudo-color
// - page bits merged after masking
// - page fills missing upper overlay bits
// - address wraps from last to zero
// - six-bit readback clears two upper bits
// - six-bit output shifted up, zero filled
module palette_access (
	input  wire logic                mclk_i,
	input  wire logic                rst_i,
	input  wire logic                ce_i,
	input  wire logic                psel_i,
	input  wire logic                penable_i,
	input  wire logic                pwrite_i,
	input  wire logic [7:0]          paddr_i,
	input  wire logic [31:0]         pwdata_i,
	output logic      [31:0]         prdata_o,
	output logic                     pready_o,
	output logic                     pslverr_o,
	input  wire logic [7:0]          pixel_i,
	output palette_pkg::color_t      rgb_o
);

	// ============================================================
	// state
	logic [7:0]                 addr_r;
	logic [7:0]                 page_r;
	logic [7:0]                 mask_r;
	palette_pkg::ctrl_t         ctrl_r;
	palette_pkg::phase_t        phase_r;
	palette_pkg::color_t        hold_r;
	logic [7:0]                 pix_addr_r;
	logic [7:0]                 pix_addr_nxt;
	logic [7:0]                 low_keep;
	logic [7:0]                 pix_masked;
	logic [7:0]                 rd_byte;
	logic [31:0]                rd_nxt;
	logic                       mapped;
	logic                       ram_we;
	palette_pkg::color_t        ram_wdata;
	palette_pkg::color_t        ram_hdata;
	palette_pkg::color_t        ram_pdata;
	logic [7:0]                 ram_haddr;
	logic [7:0]                 addr_inc;

	// ============================================================
	// apb decode
	logic setup;
	logic done;
	logic wr_done;
	logic rd_done;
	assign setup   = psel_i && !penable_i;
	assign done    = psel_i && penable_i && pready_o;
	assign wr_done = done && pwrite_i;
	assign rd_done = done && !pwrite_i;

	assign addr_inc = addr_r + 8'h01;

	always_comb begin
		mapped = 1'b1;
		unique case (paddr_i)
			palette_pkg::OFF_WADDR,
			palette_pkg::OFF_RADDR,
			palette_pkg::OFF_HOLD,
			palette_pkg::OFF_PAGE,
			palette_pkg::OFF_MASK,
			palette_pkg::OFF_CTRL,
			palette_pkg::OFF_STATUS: mapped = 1'b1;
			default:                 mapped = 1'b0;
		endcase
	end

	always_comb begin
		rd_byte = hold_r.red;
		unique case (phase_r)
			palette_pkg::PH_RED:   rd_byte = hold_r.red;
			palette_pkg::PH_GREEN: rd_byte = hold_r.green;
			palette_pkg::PH_BLUE:  rd_byte = hold_r.blue;
			default:               rd_byte = hold_r.red;
		endcase
		if (!ctrl_r.depth8) begin
			rd_byte[7:palette_pkg::SIX_W] = 2'b00;
		end
	end

	always_comb begin
		rd_nxt = 32'h0000_0000;
		unique case (paddr_i)
			palette_pkg::OFF_WADDR,
			palette_pkg::OFF_RADDR:  rd_nxt[7:0] = addr_r;
			palette_pkg::OFF_HOLD:   rd_nxt[7:0] = rd_byte;
			palette_pkg::OFF_PAGE:   rd_nxt[7:0] = page_r;
			palette_pkg::OFF_MASK:   rd_nxt[7:0] = mask_r;
			palette_pkg::OFF_CTRL:   rd_nxt[palette_pkg::CTRL_W-1:0] = ctrl_r;
			palette_pkg::OFF_STATUS: rd_nxt[9:0] = {phase_r, addr_r};
			default:                 rd_nxt = 32'h0000_0000;
		endcase
	end

	// ============================================================
	// apb response: data sampled in setup, ready in access
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pready_o  <= 1'b0;
			prdata_o  <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else if (ce_i) begin
			if (setup) begin
				pready_o  <= 1'b1;
				prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_nxt;
				pslverr_o <= !mapped;
			end else if (done) begin
				pready_o  <= 1'b0;
				pslverr_o <= 1'b0;
			end
		end
	end

	// ============================================================
	// configuration registers
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			page_r <= palette_pkg::PAGE_RST;
			mask_r <= palette_pkg::MASK_RST;
			ctrl_r <= palette_pkg::CTRL_RST;
		end else if (ce_i && wr_done) begin
			if (paddr_i == palette_pkg::OFF_PAGE) begin
				page_r <= pwdata_i[7:0];
			end
			if (paddr_i == palette_pkg::OFF_MASK) begin
				mask_r <= pwdata_i[7:0];
			end
			if (paddr_i == palette_pkg::OFF_CTRL) begin
				ctrl_r <= palette_pkg::ctrl_t'(pwdata_i[palette_pkg::CTRL_W-1:0]);
			end
		end
	end

	// ============================================================
	// host ram port
	// store concatenated entry on blue
	assign ram_we    = wr_done && paddr_i == palette_pkg::OFF_HOLD && phase_r == palette_pkg::PH_BLUE;
	assign ram_wdata = '{red: hold_r.red, green: hold_r.green, blue: pwdata_i[7:0]};
	// fetch target is the written address
	assign ram_haddr = (wr_done && paddr_i == palette_pkg::OFF_RADDR) ? pwdata_i[7:0] : addr_r;

	// ============================================================
	// address register and byte sequencer
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			addr_r  <= palette_pkg::ADDR_RST;
			phase_r <= palette_pkg::PH_RED;
		end else if (ce_i) begin
			if (wr_done && paddr_i == palette_pkg::OFF_WADDR) begin
				addr_r  <= pwdata_i[7:0];
				phase_r <= palette_pkg::PH_RED;
			end else if (wr_done && paddr_i == palette_pkg::OFF_RADDR) begin
				addr_r  <= pwdata_i[7:0] + 8'h01;
				phase_r <= palette_pkg::PH_RED;
			end else if (done && paddr_i == palette_pkg::OFF_HOLD) begin
				unique case (phase_r)
					palette_pkg::PH_RED:   phase_r <= palette_pkg::PH_GREEN;
					palette_pkg::PH_GREEN: phase_r <= palette_pkg::PH_BLUE;
					palette_pkg::PH_BLUE: begin
						phase_r <= palette_pkg::PH_RED;
						addr_r  <= addr_inc;
					end
					default:               phase_r <= palette_pkg::PH_RED;
				endcase
			end
		end
	end

	// holding register: write bytes or read-ahead entry
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			hold_r <= '0;
		end else if (ce_i) begin
			if (wr_done && paddr_i == palette_pkg::OFF_RADDR) begin
				hold_r <= ram_hdata;
			end else if (wr_done && paddr_i == palette_pkg::OFF_HOLD) begin
				unique case (phase_r)
					palette_pkg::PH_RED:   hold_r.red   <= pwdata_i[7:0];
					palette_pkg::PH_GREEN: hold_r.green <= pwdata_i[7:0];
					palette_pkg::PH_BLUE:  hold_r.blue  <= pwdata_i[7:0];
					default:               hold_r.red   <= pwdata_i[7:0];
				endcase
			end else if (rd_done && paddr_i == palette_pkg::OFF_HOLD && phase_r == palette_pkg::PH_BLUE) begin
				hold_r <= ram_hdata;
			end
		end
	end

	// ============================================================
	// pixel lookup address
	always_comb begin
		unique case (ctrl_r.planes)
			palette_pkg::PLANES_8: low_keep = 8'hff;
			palette_pkg::PLANES_4: low_keep = 8'h0f;
			palette_pkg::PLANES_2: low_keep = 8'h03;
			palette_pkg::PLANES_1: low_keep = 8'h01;
			default:               low_keep = 8'hff;
		endcase
		pix_masked = ctrl_r.direct ? pixel_i : (pixel_i & mask_r);
		pix_addr_nxt = (pix_masked & low_keep) | (page_r & ~low_keep);
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pix_addr_r <= 8'h00;
		end else if (ce_i) begin
			pix_addr_r <= pix_addr_nxt;
		end
	end

	palette_ram u_ram (
		.mclk_i  (mclk_i),
		.ce_i    (ce_i),
		.we_i    (ram_we),
		.waddr_i (addr_r),
		.wdata_i (ram_wdata),
		.haddr_i (ram_haddr),
		.hdata_o (ram_hdata),
		.paddr_i (pix_addr_r),
		.pdata_o (ram_pdata)
	);

	// ============================================================
	// output colour; six-bit data moved up to the dac range
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rgb_o <= '0;
		end else if (ce_i) begin
			if (ctrl_r.depth8) begin
				rgb_o <= ram_pdata;
			end else begin
				rgb_o <= '{red:   {ram_pdata.red[5:0], 2'b00},
				           green: {ram_pdata.green[5:0], 2'b00},
				           blue:  {ram_pdata.blue[5:0], 2'b00}};
			end
		end
	end

	// ============================================================
	// assertions
	logic addr_wr_ev;
	logic raddr_wr_ev;
	logic blue_ev;
	assign addr_wr_ev  = ce_i && wr_done && paddr_i == palette_pkg::OFF_WADDR;
	assign raddr_wr_ev = ce_i && wr_done && paddr_i == palette_pkg::OFF_RADDR;
	assign blue_ev     = ce_i && done && paddr_i == palette_pkg::OFF_HOLD && phase_r == palette_pkg::PH_BLUE;

	a_start_addr: assert property (@(posedge mclk_i) disable iff (rst_i)
		addr_wr_ev |=> addr_r == $past(pwdata_i[7:0]) && phase_r == palette_pkg::PH_RED)
		else $error("address write not loaded");

	// checks the stored word itself, not the write strobe that the same decode produces
	a_store_entry: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && wr_done && paddr_i == palette_pkg::OFF_HOLD && phase_r == palette_pkg::PH_BLUE)
		|=> u_ram.mem[$past(addr_r)] == {$past(hold_r.red), $past(hold_r.green), $past(pwdata_i[7:0])})
		else $error("entry not stored on blue byte");

	a_addr_advance: assert property (@(posedge mclk_i) disable iff (rst_i)
		blue_ev |=> addr_r == 8'($past(addr_r) + 8'h01) && phase_r == palette_pkg::PH_RED)
		else $error("address did not advance after blue");

	a_read_fetch: assert property (@(posedge mclk_i) disable iff (rst_i)
		raddr_wr_ev |=> hold_r == $past(ram_hdata) && addr_r == 8'($past(pwdata_i[7:0]) + 8'h01))
		else $error("read-mode fetch wrong");

	a_byte_order: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && done && paddr_i == palette_pkg::OFF_HOLD && phase_r == palette_pkg::PH_RED)
		|=> phase_r == palette_pkg::PH_GREEN)
		else $error("sequencer skipped green");

	a_read_ahead: assert property (@(posedge mclk_i) disable iff (rst_i)
		(blue_ev && !pwrite_i) |=> hold_r == $past(ram_hdata))
		else $error("read-ahead entry not loaded");

	a_page_four: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && ctrl_r.planes == palette_pkg::PLANES_4)
		|=> pix_addr_r[7:4] == $past(page_r[7:4]) && pix_addr_r[3:0] == $past(pix_masked[3:0]))
		else $error("four-plane address split wrong");

	a_page_one: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && ctrl_r.planes == palette_pkg::PLANES_1) |=> pix_addr_r[7:1] == $past(page_r[7:1]))
		else $error("one-plane page bits wrong");

	a_mask_and: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && !ctrl_r.direct && ctrl_r.planes == palette_pkg::PLANES_8)
		|=> pix_addr_r == $past(pixel_i & mask_r))
		else $error("pixel not masked");

	a_addr_wrap: assert property (@(posedge mclk_i) disable iff (rst_i)
		(blue_ev && addr_r == 8'hff) |=> addr_r == 8'h00)
		else $error("address did not wrap");

	a_six_read: assert property (@(posedge mclk_i) disable iff (rst_i)
		(psel_i && penable_i && !pwrite_i && paddr_i == palette_pkg::OFF_HOLD && !ctrl_r.depth8)
		|-> prdata_o[7:6] == 2'b00)
		else $error("six-bit readback upper bits set");

	a_six_out: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && !ctrl_r.depth8) |=> rgb_o.red[1:0] == 2'b00 && rgb_o.blue[7:2] == $past(ram_pdata.blue[5:0]))
		else $error("six-bit output not shifted");

	a_seq_restart: assert property (@(posedge mclk_i) disable iff (rst_i)
		raddr_wr_ev |=> phase_r == palette_pkg::PH_RED)
		else $error("sequencer not restarted");

	c_block_write: cover property (@(posedge mclk_i) disable iff (rst_i)
		(blue_ev && pwrite_i) ##[1:40] (blue_ev && pwrite_i));
	c_block_read: cover property (@(posedge mclk_i) disable iff (rst_i)
		raddr_wr_ev ##[1:40] (blue_ev && !pwrite_i));
	c_six_bit: cover property (@(posedge mclk_i) disable iff (rst_i)
		rd_done && paddr_i == palette_pkg::OFF_HOLD && !ctrl_r.depth8);
	c_wrap: cover property (@(posedge mclk_i) disable iff (rst_i)
		blue_ev && addr_r == 8'hff);

endmodule

// File: verif/apb_host_model.sv
`timescale 1ns/1ps
// ============================================================
// host processor: one apb transfer per palette byte
module apb_host_model (
	input  wire logic        mclk_i,
	output logic             psel_o,
	output logic             penable_o,
	output logic             pwrite_o,
	output logic [7:0]       paddr_o,
	output logic [31:0]      pwdata_o,
	input  wire logic [31:0] prdata_i,
	input  wire logic        pready_i,
	input  wire logic        pslverr_i
);
	initial begin
		psel_o = 1'h0;
		penable_o = 1'h0;
		pwrite_o = 1'h0;
		paddr_o = 8'h00;
		pwdata_o = 32'h0;
	end
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err, output logic to);
		int n;
		n = 0;
		@(posedge mclk_i);
		psel_o <= 1'h1;
		penable_o <= 1'h0;
		pwrite_o <= wr;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge mclk_i);
		penable_o <= 1'h1;
		do begin
			@(posedge mclk_i);
			n++;
		end while (pready_i !== 1'h1 && n < 64);
		q = prdata_i;
		err = pslverr_i;
		to = (pready_i !== 1'h1);
		psel_o <= 1'h0;
		penable_o <= 1'h0;
		// released data must not look like the last value
		pwdata_o <= ~d;
	endtask
endmodule

// File: verif/palette_access_tb.sv
`timescale 1ns/1ps
module palette_access_tb;
	logic                mclk_i;
	logic                rst_i;
	logic                ce_i;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [7:0]          paddr;
	logic [31:0]         pwdata;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic [7:0]          pixel_i;
	palette_pkg::color_t rgb_o;
	logic [31:0]         q;
	logic                err;
	int                  n_mismatch;
	int                  n_checks;

	palette_access i_palette_access (
		.mclk_i    (mclk_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.psel_i    (psel),
		.penable_i (penable),
		.pwrite_i  (pwrite),
		.paddr_i   (paddr),
		.pwdata_i  (pwdata),
		.prdata_o  (prdata),
		.pready_o  (pready),
		.pslverr_o (pslverr),
		.pixel_i   (pixel_i),
		.rgb_o     (rgb_o)
	);
	apb_host_model i_apb_host_model (
		.mclk_i    (mclk_i),
		.psel_o    (psel),
		.penable_o (penable),
		.pwrite_o  (pwrite),
		.paddr_o   (paddr),
		.pwdata_o  (pwdata),
		.prdata_i  (prdata),
		.pready_i  (pready),
		.pslverr_i (pslverr)
	);

	// ============================================================
	// helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic to;
		i_apb_host_model.xfer(w, a, d, q, err, to);
		if (to) begin
			n_mismatch++;
			stop_test();
		end
	endtask
	task automatic chkr(input logic [7:0] a, input logic [9:0] exp, input logic [9:0] msk);
		acc(1'h0, a, 32'h0);
		chk({31'h0, err}, 32'h0);
		chk({22'h0, q[9:0] & msk}, {22'h0, exp});
	endtask
	// entry contents chosen so every byte differs per index
	function automatic palette_pkg::color_t ent(input logic [7:0] i);
		return '{red: i, green: ~i, blue: i ^ 8'h5a};
	endfunction
	task automatic pxm(input logic [3:0] ctl, input logic [7:0] a);
		acc(1'h1, palette_pkg::OFF_CTRL, {28'h0, ctl});
		repeat (5) @(posedge mclk_i);
		chk({8'h0, rgb_o}, {8'h0, ent(a)});
	endtask

	// ============================================================
	// scenarios
	task automatic t_regs();
		chkr(palette_pkg::OFF_PAGE, 10'h000, 10'h0ff);
		chkr(palette_pkg::OFF_MASK, 10'h0ff, 10'h0ff);
		chkr(palette_pkg::OFF_CTRL, 10'h001, 10'h00f);
		chkr(palette_pkg::OFF_STATUS, 10'h000, 10'h3ff);
		acc(1'h1, palette_pkg::OFF_PAGE, 32'h5a);
		chkr(palette_pkg::OFF_PAGE, 10'h05a, 10'h0ff);
		acc(1'h0, 8'h1c, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(q, 32'h0);
		// a write to a hole must answer with an error and change nothing
		acc(1'h1, 8'h1c, 32'h33);
		chk({31'h0, err}, 32'h1);
		chkr(palette_pkg::OFF_PAGE, 10'h05a, 10'h0ff);
		$display("done regs");
	endtask
	task automatic t_fill();
		palette_pkg::color_t c;
		acc(1'h1, palette_pkg::OFF_WADDR, 32'h0);
		for (int i = 0; i < 256; i++) begin
			c = ent(8'(i));
			acc(1'h1, palette_pkg::OFF_HOLD, {24'h0, c.red});
			acc(1'h1, palette_pkg::OFF_HOLD, {24'h0, c.green});
			acc(1'h1, palette_pkg::OFF_HOLD, {24'h0, c.blue});
		end
		chkr(palette_pkg::OFF_STATUS, 10'h000, 10'h3ff);
		$display("done fill");
	endtask
	task automatic t_read();
		palette_pkg::color_t c;
		acc(1'h1, palette_pkg::OFF_RADDR, 32'hfe);
		chkr(palette_pkg::OFF_STATUS, 10'h0ff, 10'h3ff);
		for (int i = 0; i < 2; i++) begin
			c = ent(8'hfe + 8'(i));
			chkr(palette_pkg::OFF_HOLD, {2'h0, c.red}, 10'h0ff);
			chkr(palette_pkg::OFF_HOLD, {2'h0, c.green}, 10'h0ff);
			chkr(palette_pkg::OFF_HOLD, {2'h0, c.blue}, 10'h0ff);
		end
		chkr(palette_pkg::OFF_STATUS, 10'h001, 10'h3ff);
		$display("done read");
	endtask
	task automatic t_partial();
		acc(1'h1, palette_pkg::OFF_WADDR, 32'h05);
		chkr(palette_pkg::OFF_WADDR, 10'h005, 10'h0ff);
		acc(1'h1, palette_pkg::OFF_HOLD, 32'h11);
		acc(1'h1, palette_pkg::OFF_HOLD, 32'h22);
		chkr(palette_pkg::OFF_STATUS, 10'h205, 10'h3ff);
		acc(1'h1, palette_pkg::OFF_RADDR, 32'h05);
		chkr(palette_pkg::OFF_STATUS, 10'h006, 10'h3ff);
		chkr(palette_pkg::OFF_RADDR, 10'h006, 10'h0ff);
		chkr(palette_pkg::OFF_HOLD, 10'h005, 10'h0ff);
		$display("done partial");
	endtask
	task automatic t_six();
		acc(1'h1, palette_pkg::OFF_CTRL, 32'h0);
		acc(1'h1, palette_pkg::OFF_RADDR, 32'hfe);
		chkr(palette_pkg::OFF_HOLD, 10'h03e, 10'h0ff);
		chkr(palette_pkg::OFF_HOLD, 10'h001, 10'h0ff);
		chkr(palette_pkg::OFF_HOLD, 10'h024, 10'h0ff);
		@(posedge mclk_i);
		pixel_i <= 8'hfe;
		repeat (5) @(posedge mclk_i);
		chk({8'h0, rgb_o}, 32'hf80490);
		acc(1'h1, palette_pkg::OFF_CTRL, 32'h1);
		acc(1'h1, palette_pkg::OFF_RADDR, 32'hfe);
		chkr(palette_pkg::OFF_HOLD, 10'h0fe, 10'h0ff);
		$display("done six");
	endtask
	task automatic t_planes();
		acc(1'h1, palette_pkg::OFF_MASK, 32'h3d);
		@(posedge mclk_i);
		pixel_i <= 8'h97;
		pxm(4'h1, 8'h15);
		pxm(4'h3, 8'h55);
		pxm(4'h5, 8'h59);
		pxm(4'h7, 8'h5b);
		pxm(4'hb, 8'h57);
		pxm(4'h9, 8'h97);
		acc(1'h1, palette_pkg::OFF_RADDR, 32'h10);
		chkr(palette_pkg::OFF_HOLD, 10'h010, 10'h0ff);
		chk({8'h0, rgb_o}, {8'h0, ent(8'h97)});
		@(posedge mclk_i);
		ce_i <= 1'h0;
		pixel_i <= 8'h00;
		repeat (6) @(posedge mclk_i);
		chk({8'h0, rgb_o}, {8'h0, ent(8'h97)});
		ce_i <= 1'h1;
		repeat (5) @(posedge mclk_i);
		chk({8'h0, rgb_o}, {8'h0, ent(8'h00)});
		$display("done planes");
	endtask

	// ============================================================
	// clock, reset and sequence
	initial begin
		mclk_i = 1'h0;
		forever #5 mclk_i = ~mclk_i;
	end
	initial begin
		n_mismatch = 0;
		n_checks = 0;
		rst_i = 1'h1;
		ce_i = 1'h1;
		pixel_i = 8'h00;
		repeat (8) @(posedge mclk_i);
		chk({8'h0, rgb_o}, 32'h0);
		rst_i <= 1'h0;
		t_regs();
		t_fill();
		t_read();
		t_partial();
		t_six();
		t_planes();
		stop_test();
	end
endmodule
